// >>> hdl/trs_map.svh
// Offsets, control bit positions and timing counts shared by both ends
`ifndef TRS_MAP_SVH
`define TRS_MAP_SVH
`define TRS_CLK_MHZ          100
`define TRS_PD_MIN_NS        1000
`define TRS_PD_CYC           ((`TRS_PD_MIN_NS * `TRS_CLK_MHZ + 999) / 1000)
`define TRS_RXA_GAP_CYC      5
`define TRS_SIM_BUSY_CYC     20
`define TRS_SETTLE_CYC       4000
`define TRS_IDLE_MIN_CYC     1
`define TRS_CNT_W            16
`define TRS_REG_CTRL         4'h0
`define TRS_REG_STAT         4'h1
`define TRS_CTRL_LAUNCH      0
`define TRS_CTRL_PWRDN       1
`define TRS_CTRL_FAST        2
`define TRS_CTRL_USEPD       3
`define TRS_CTRL_IDLE        4
`define TRS_CTRL_UNUSED      5
`endif

// >>> hdl/trs_pkg.sv
// Types shared by both ends of the reconfiguration reset link
package trs_pkg;
    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_PD, SEQ_HOLD, SEQ_TXREL, SEQ_GAP, SEQ_LOCK,
        SEQ_SETTLE, SEQ_RUN
    } trs_seq_t;
    typedef enum logic [1:0] {
        DEV_IDLE, DEV_BUSY, DEV_DONE
    } trs_dev_t;
endpackage : trs_pkg

// >>> hdl/trs_link_if.sv
// Link between user reset logic and the transceiver channel model
`timescale 1ns/1ps
interface trs_link_if;
    logic txLogicHold;
    logic rxAnalogHold;
    logic rxLogicHold;
    logic blockPowerDown;
    logic commitWrite;
    logic txIdleForce;
    logic busy;
    logic chanUpdateDone;
    logic rxFreqLock;
    modport device (
        input  txLogicHold, rxAnalogHold, rxLogicHold, blockPowerDown,
        input  commitWrite, txIdleForce,
        output busy, chanUpdateDone, rxFreqLock
    );
    modport host (
        output txLogicHold, rxAnalogHold, rxLogicHold, blockPowerDown,
        output commitWrite, txIdleForce,
        input  busy, chanUpdateDone, rxFreqLock
    );
endinterface : trs_link_if

// >>> hdl/trs_channel.sv
// Transceiver channel and reconfiguration controller end
`timescale 1ns/1ps
`include "trs_map.svh"
module trs_channel
    import trs_pkg::*;
(
    input  wire logic   mclk,
    input  wire logic   sys_rst,
    trs_link_if.device  lnk,
    input  wire logic   chanUnused,
    input  wire logic   cdrLockIn,
    output logic        chanPoweredDown,
    output logic        offsetCalDone
);
    typedef struct packed {
        trs_dev_t              st;
        logic [`TRS_CNT_W-1:0] cnt;
        logic                  busy;
        logic                  done;
        logic                  cal;
        logic                  pd;
        logic                  lock;
    } trs_chan_t;

    trs_chan_t cur_r;
    trs_chan_t cur_nxt;

    always_comb begin
        cur_nxt = cur_r;
        // Unused channels and block power-down both hold the channel off
        cur_nxt.pd = chanUnused | lnk.blockPowerDown; // [RULE_07] [RULE_08]
        cur_nxt.lock = cdrLockIn & ~cur_nxt.pd & ~lnk.rxAnalogHold;
        if (cur_nxt.pd) begin
            cur_nxt.st   = DEV_IDLE;
            cur_nxt.busy = 1'b0;
            cur_nxt.done = 1'b0;
            cur_nxt.cal  = 1'b0;
            cur_nxt.cnt  = '0;
        end else begin
            unique case (cur_r.st)
                DEV_IDLE: begin
                    if (lnk.commitWrite) begin
                        cur_nxt.st   = DEV_BUSY;
                        cur_nxt.busy = 1'b1; // [RULE_02]
                        cur_nxt.done = 1'b0;
                        cur_nxt.cal  = 1'b0;
                        cur_nxt.cnt  = '0;
                    end
                end
                DEV_BUSY: begin
                    // Short model timing; silicon takes far longer
                    cur_nxt.cnt = cur_r.cnt + 1'b1;
                    if (cur_r.cnt == `TRS_CNT_W'(`TRS_SIM_BUSY_CYC - 1)) begin
                        cur_nxt.st   = DEV_DONE;
                        cur_nxt.busy = 1'b0; // [RULE_14]
                        cur_nxt.cal  = 1'b1; // [RULE_10]
                        cur_nxt.done = 1'b1; // [RULE_03]
                    end
                end
                DEV_DONE: begin
                    if (lnk.commitWrite) begin
                        cur_nxt.st   = DEV_BUSY;
                        cur_nxt.busy = 1'b1;
                        cur_nxt.done = 1'b0;
                        cur_nxt.cal  = 1'b0;
                        cur_nxt.cnt  = '0;
                    end
                end
                default: cur_nxt.st = DEV_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cur_r <= '{st: DEV_IDLE, cnt: '0, busy: 1'b0, done: 1'b0,
                       cal: 1'b0, pd: 1'b1, lock: 1'b0};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign lnk.busy           = cur_r.busy;
    assign lnk.chanUpdateDone = cur_r.done;
    assign lnk.rxFreqLock     = cur_r.lock;
    assign chanPoweredDown    = cur_r.pd;
    assign offsetCalDone      = cur_r.cal;
endmodule : trs_channel

// >>> hdl/trs_reset_ctrl.sv
// User reset logic driving the channel holds after a reconfiguration
// Overview of operation
// (RULE_01) On launch assert all three holds together
// (RULE_02) Device raises busy on commit write
// (RULE_03) Wait channel update complete before releasing
// (RULE_04) Then release transmitter logic hold first
// (RULE_05) Count five clocks, then release analog hold
// (RULE_06) Await frequency lock plus settle, release logic
// (RULE_07) Unused channels stay powered down
// (RULE_08) Block power-down powers off whole block
// (RULE_09) Block power-down pulse lasts at least 1us
// (RULE_10) Busy falls when offset cancellation completes
// (RULE_11) Without power-down, drive holds in order
// (RULE_12) Power-down only: assert at least one clock
// (RULE_13) Fast mode skips the settle wait
// (RULE_14) Model busy drops after about 20 clocks
// (RULE_15) Force transmit idle one clock before data
// (RULE_16) Synchronise status; restart if lock drops; code restarts only in the settle wait, not in fast mode or after ready
`timescale 1ns/1ps
`include "trs_map.svh"
module trs_reset_ctrl
    import trs_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = `TRS_SETTLE_CYC
)(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    trs_link_if.host         lnk,
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrStb,
    input  wire logic        regRdStb,
    output logic      [7:0]  regRdData,
    output logic             rxReady
);
    typedef struct packed {
        trs_seq_t              st;
        logic [`TRS_CNT_W-1:0] cnt;
        logic [5:0]            ctrl;
        logic [2:0][2:0]       sync;
        logic                  txH;
        logic                  rxaH;
        logic                  rxlH;
        logic                  pd;
        logic                  commit;
        logic                  idle;
        logic                  ready;
        logic [7:0]            rd;
    } trs_host_t;

    trs_host_t  cur_r;
    trs_host_t  cur_nxt;
    logic [2:0] stsRaw;
    logic [2:0] stsHigh;
    logic [2:0] stsLow;
    logic       doneQ;
    logic       doneClear;
    logic       lockQ;
    logic       lockLost;
    logic       busyLow;

    // Status order in the stage array: completion, lock, busy
    assign stsRaw = {lnk.busy, lnk.rxFreqLock, lnk.chanUpdateDone};

    // A change counts once the second and third stages agree
    for (genvar i = 0; i < 3; i++) begin : g_sts
        assign stsHigh[i] = cur_r.sync[i][1] & cur_r.sync[i][2]; // [RULE_16]
        assign stsLow[i]  = ~cur_r.sync[i][1] & ~cur_r.sync[i][2];
    end

    assign doneQ     = stsHigh[0];
    assign doneClear = stsLow[0];
    assign lockQ     = stsHigh[1];
    assign lockLost  = stsLow[1];
    assign busyLow   = stsLow[2];

    always_comb begin
        cur_nxt = cur_r;
        for (int i = 0; i < 3; i++) begin
            cur_nxt.sync[i] = {cur_r.sync[i][1:0], stsRaw[i]};
        end
        cur_nxt.commit = 1'b0;
        cur_nxt.rd = 8'h00;
        if (regRdStb) begin
            if (regAddr == `TRS_REG_CTRL) begin
                cur_nxt.rd = {2'b00, cur_r.ctrl};
            end else if (regAddr == `TRS_REG_STAT) begin
                cur_nxt.rd = {1'b0,
                              cur_r.st,
                              cur_r.ready,
                              cur_r.rxlH,
                              cur_r.rxaH,
                              cur_r.txH};
            end
        end
        if (regWrStb && regAddr == `TRS_REG_CTRL) begin
            cur_nxt.ctrl = regWrData[5:0];
        end
        // Launch is a self-clearing bit; the write itself does not stick
        cur_nxt.ctrl[`TRS_CTRL_LAUNCH] = 1'b0;
        unique case (cur_r.st)
            SEQ_IDLE, SEQ_RUN: begin
                if (regWrStb && regAddr == `TRS_REG_CTRL) begin
                    if (regWrData[`TRS_CTRL_PWRDN]) begin
                        cur_nxt.st  = SEQ_PD;
                        cur_nxt.pd  = 1'b1;
                        cur_nxt.cnt = '0;
                    end else if (regWrData[`TRS_CTRL_LAUNCH]) begin
                        cur_nxt.st     = SEQ_HOLD;
                        cur_nxt.commit = 1'b1;
                        cur_nxt.txH    = 1'b1; // [RULE_01]
                        cur_nxt.rxaH   = 1'b1; // [RULE_01] [RULE_11]
                        cur_nxt.rxlH   = 1'b1; // [RULE_01]
                        cur_nxt.ready  = 1'b0;
                    end
                end
            end
            SEQ_PD: begin
                // 1us covers the one-clock simulation minimum as well
                cur_nxt.cnt = cur_r.cnt + 1'b1;
                if (cur_r.cnt == `TRS_CNT_W'(`TRS_PD_CYC - 1)) begin
                    cur_nxt.pd = 1'b0; // [RULE_09] [RULE_12]
                    cur_nxt.st = SEQ_IDLE;
                end
            end
            SEQ_HOLD: begin
                // A completion left over from the last launch must clear
                // first, or the holds would drop while still busy
                if (doneClear) begin
                    cur_nxt.st = SEQ_TXREL;
                end
            end
            SEQ_TXREL: begin
                // Busy falling marks offset cancellation as finished
                if (doneQ && busyLow) begin
                    cur_nxt.txH = 1'b0; // [RULE_03] [RULE_04] [RULE_10]
                    cur_nxt.st  = SEQ_GAP;
                    cur_nxt.cnt = '0;
                end
            end
            SEQ_GAP: begin
                // Gap lets the transmitter settle before the receiver wakes
                cur_nxt.cnt = cur_r.cnt + 1'b1;
                if (cur_r.cnt == `TRS_CNT_W'(`TRS_RXA_GAP_CYC - 1)) begin
                    cur_nxt.rxaH = 1'b0; // [RULE_05]
                    cur_nxt.st   = SEQ_LOCK;
                end
            end
            SEQ_LOCK: begin
                // Lock must agree in two stages, so a glitch is ignored
                if (lockQ) begin
                    cur_nxt.cnt = '0;
                    if (cur_r.ctrl[`TRS_CTRL_FAST]) begin
                        cur_nxt.rxlH = 1'b0; // [RULE_13]
                        cur_nxt.st   = SEQ_RUN;
                        cur_nxt.ready = 1'b1;
                    end else begin
                        cur_nxt.st = SEQ_SETTLE;
                    end
                end
            end
            SEQ_SETTLE: begin
                // A lock drop restarts the wait from the lock step
                cur_nxt.cnt = cur_r.cnt + 1'b1;
                if (lockLost) begin
                    cur_nxt.st = SEQ_LOCK; // [RULE_16]
                end else if (cur_r.cnt ==
                             `TRS_CNT_W'(SETTLE_CYC - 1)) begin
                    cur_nxt.rxlH  = 1'b0; // [RULE_06]
                    cur_nxt.st    = SEQ_RUN;
                    cur_nxt.ready = 1'b1;
                end
            end
        endcase
        // Idle stays forced until the receiver side is up
        cur_nxt.idle = cur_r.ctrl[`TRS_CTRL_IDLE] & ~cur_nxt.ready; // [RULE_15]
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            // Holds and idle force start asserted so nothing runs early
            cur_r <= '{st:     SEQ_IDLE,
                       cnt:    '0,
                       ctrl:   '0,
                       sync:   '0,
                       txH:    1'b1,
                       rxaH:   1'b1,
                       rxlH:   1'b1,
                       pd:     1'b0,
                       commit: 1'b0,
                       idle:   1'b1,
                       ready:  1'b0,
                       rd:     8'h00};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // Link outputs come straight from flip-flops, free of glitches
    assign lnk.txLogicHold    = cur_r.txH;
    assign lnk.rxAnalogHold   = cur_r.rxaH;
    assign lnk.rxLogicHold    = cur_r.rxlH;
    assign lnk.blockPowerDown = cur_r.pd;
    assign lnk.commitWrite    = cur_r.commit;
    assign lnk.txIdleForce    = cur_r.idle;
    assign regRdData          = cur_r.rd;
    assign rxReady            = cur_r.ready;
endmodule : trs_reset_ctrl

// >>> test/trs_monitor.sv
// Assertions watching the reset link between the two ends
`timescale 1ns/1ps
`include "trs_map.svh"
module trs_monitor (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic txLogicHold,
    input wire logic rxAnalogHold,
    input wire logic rxLogicHold,
    input wire logic blockPowerDown,
    input wire logic commitWrite,
    input wire logic txIdleForce,
    input wire logic busy,
    input wire logic chanUpdateDone,
    input wire logic rxFreqLock
);
    logic [7:0] pdCnt_r;
    // Saturation is not needed: the pulse is far below 255 cycles
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) pdCnt_r <= 8'h00;
        else pdCnt_r <= blockPowerDown ? pdCnt_r + 8'h01 : 8'h00;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_holds; txLogicHold && rxAnalogHold && rxLogicHold; endsequence
    sequence s_busy_end; busy ##1 (!busy && chanUpdateDone); endsequence
    property p_launch; commitWrite |-> s_holds; endproperty
    property p_busy_up; commitWrite |=> busy; endproperty
    property p_busy_len; $rose(busy) |-> ##19 s_busy_end; endproperty
    property p_tx_rel; $fell(txLogicHold) |-> chanUpdateDone; endproperty
    property p_gap;
        $fell(rxAnalogHold) |-> !txLogicHold && !$past(txLogicHold, 5);
    endproperty
    property p_rxl_rel;
        $fell(rxLogicHold) |-> rxFreqLock && !rxAnalogHold && !txLogicHold;
    endproperty
    property p_pd_len;
        $fell(blockPowerDown) |-> pdCnt_r >= `TRS_PD_CYC;
    endproperty
    property p_lock_gate; rxAnalogHold |=> !rxFreqLock; endproperty
    property p_busy_done; $fell(txLogicHold) |-> !busy; endproperty
    a_launch: assert property (p_launch)
        else $error("holds not all set at commit");
    a_busy_up: assert property (p_busy_up)
        else $error("busy late after commit");
    a_busy_len: assert property (p_busy_len)
        else $error("busy length or done wrong");
    a_tx_rel: assert property (p_tx_rel)
        else $error("tx hold released before done");
    a_gap: assert property (p_gap)
        else $error("analog hold released too soon");
    a_rxl_rel: assert property (p_rxl_rel)
        else $error("logic hold released out of order");
    a_pd_len: assert property (p_pd_len)
        else $error("power-down pulse too short");
    a_lock_gate: assert property (p_lock_gate)
        else $error("lock shown under analog hold");
    a_busy_done: assert property (p_busy_done)
        else $error("tx hold released while busy");
endmodule : trs_monitor

// >>> test/testbench.sv
// Self-checking bench joining the reset logic to the channel model
`timescale 1ns/1ps
`include "trs_map.svh"
module testbench;
    localparam int SETTLE = 20;
    logic mclk, sys_rst, regWrStb, regRdStb, rdPend, chanUnused, cdrLockIn;
    logic [3:0] regAddr;
    logic [7:0] regWrData, regRdData, expQ[$];
    logic rxReady, chanPoweredDown, offsetCalDone;
    logic [16:0] lfsr;
    int mismatches, n_compared, cnt;
    trs_link_if lnk ();
    trs_reset_ctrl #(.SETTLE_CYC(SETTLE)) i_trs_reset_ctrl (.mclk(mclk),
        .sys_rst(sys_rst), .lnk(lnk), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .rxReady(rxReady));
    trs_channel i_trs_channel (.mclk(mclk), .sys_rst(sys_rst), .lnk(lnk),
        .chanUnused(chanUnused), .cdrLockIn(cdrLockIn),
        .chanPoweredDown(chanPoweredDown), .offsetCalDone(offsetCalDone));
    trs_monitor i_trs_monitor (.mclk(mclk), .sys_rst(sys_rst),
        .txLogicHold(lnk.txLogicHold), .rxAnalogHold(lnk.rxAnalogHold),
        .rxLogicHold(lnk.rxLogicHold), .blockPowerDown(lnk.blockPowerDown),
        .commitWrite(lnk.commitWrite), .txIdleForce(lnk.txIdleForce),
        .busy(lnk.busy), .chanUpdateDone(lnk.chanUpdateDone),
        .rxFreqLock(lnk.rxFreqLock));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task report_and_stop;
        $display("TB: %0d mismatches of %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [16:0] lfsr_next(input logic [16:0] s);
        lfsr_next = {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr_next
    task wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge mclk);
        regWrStb <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] e);
        regAddr <= a;
        regRdStb <= 1'b1;
        expQ.push_back(e);
        @(posedge mclk);
        regRdStb <= 1'b0;
        @(posedge mclk);
    endtask : rd
    // Read data stand one cycle only, so the note is matched at mid-cycle
    always @(posedge mclk) rdPend <= regRdStb;
    always @(negedge mclk) begin
        if (rdPend === 1'b1) chk(regRdData, expQ.pop_front());
    end
    task launch(input logic f, input logic drop);
        cdrLockIn <= 1'b0;
        lfsr = lfsr_next(lfsr);
        wr(`TRS_REG_CTRL, 8'h19 | {5'h00, f, 2'h0});
        chk(lnk.txIdleForce, 1'b1);
        for (cnt = 0; cnt < 100 && lnk.txLogicHold !== 1'b0; cnt++)
            @(posedge mclk);
        chk({lnk.chanUpdateDone, offsetCalDone, lnk.rxAnalogHold}, 3'h7);
        for (cnt = 0; cnt < 20 && lnk.rxAnalogHold !== 1'b0; cnt++)
            @(posedge mclk);
        chk(lnk.rxAnalogHold, 1'b0);
        chk(lnk.rxLogicHold, 1'b1);
        repeat (lfsr[3:0]) @(posedge mclk);
        cdrLockIn <= 1'b1;
        for (cnt = 0; cnt < 20 && lnk.rxFreqLock !== 1'b1; cnt++)
            @(posedge mclk);
        chk(lnk.rxFreqLock, 1'b1);
        if (drop) begin
            repeat (3) @(posedge mclk);
            cdrLockIn <= 1'b0;
            repeat (4) @(posedge mclk);
            cdrLockIn <= 1'b1;
            repeat (18) @(posedge mclk);
            chk(rxReady, 1'b0);
        end
        // A drop run has already spent 18 cycles since lock came back
        for (cnt = drop ? 18 : 0; cnt < 218 && rxReady !== 1'b1; cnt++)
            @(posedge mclk);
        chk(rxReady, 1'b1);
        chk(cnt >= SETTLE, !f);
        chk(lnk.txIdleForce, 1'b0);
        rd(`TRS_REG_STAT, 8'h78);
    endtask : launch
    initial begin
        regAddr = 4'h0;
        regWrData = 8'h00;
        {regWrStb, regRdStb, chanUnused, cdrLockIn} = 4'h0;
        lfsr = 17'h1_065B;
        mismatches = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd(`TRS_REG_STAT, 8'h07);
        lfsr = lfsr_next(lfsr);
        wr(4'h9, lfsr[7:0]);
        rd(4'h9, 8'h00);
        wr(`TRS_REG_CTRL, 8'h18);
        rd(`TRS_REG_CTRL, 8'h18);
        launch(1'b0, 1'b1);
        launch(1'b1, 1'b0);
        launch(1'b0, 1'b0);
        wr(`TRS_REG_CTRL, 8'h0A);
        for (cnt = 0; cnt < 20 && lnk.blockPowerDown !== 1'b1; cnt++)
            @(posedge mclk);
        for (cnt = 0; cnt < 300 && lnk.blockPowerDown === 1'b1; cnt++) begin
            if (cnt == 50) chk(chanPoweredDown, 1'b1);
            @(posedge mclk);
        end
        chk(cnt, `TRS_PD_CYC);
        chanUnused <= 1'b1;
        repeat (3) @(posedge mclk);
        chk({chanPoweredDown, lnk.rxFreqLock}, 2'h2);
        report_and_stop();
    end
    // Whole run is well under 500 cycles; this leaves wide margin
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        report_and_stop();
    end
endmodule : testbench
